//--- uart_bt_regs.svh
// Register indices, field positions and reset values of the baud and transmit block.
`ifndef UART_BT_REGS_SVH
`define UART_BT_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define BAUD_IDX 6'h00
`define CTRL_IDX 6'h01
`define DATA_IDX 6'h02
`define STATUS_IDX 6'h03
`define RX_SAMPLING_IDX 6'h0b
`define IDX_LSB 2
`define IDX_MSB 7

// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_TE 0
`define CTRL_BRK 1
`define CTRL_INV 2
`define CTRL_NINE 3
`define CTRL_TEN 4
`define CTRL_TWO_STOP 5
`define CTRL_LONG_BRK 6
`define CTRL_OSR_LSB 8
`define CTRL_OSR_MSB 12
`define CTRL_W 13
`define CTRL_RESET 13'h0f00

// ****************************************************************
// Status and receiver sampling fields
// ****************************************************************
`define STAT_TX_BUFFER_EMPTY_FLAG 0
`define STAT_TC 1
`define RXS_RESYNC_INH 0
`define RXS_DUAL_EDGE 1
`define RXS_W 2
`define RXS_RESET 2'h0

// ****************************************************************
// Baud divisor, ratio and frame figures
// ****************************************************************
`define DIV_W 13
`define BAUD_RESET 13'h0004
`define OSR_MIN 5'h03
`define OSR_DEFAULT_RATIO 6'h10
`define FRAME_BASE 5'h0a
`define LONG_BRK_EXTRA 5'h03
`define SH_W 16
`define DATA_W 10

`endif

//--- uart_bt_pkg.sv
// Shared types of the baud and transmit block and its remote receiver.
package uart_bt_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	typedef logic [12:0] divisor_t;
	typedef logic [9:0] char_t;
endpackage : uart_bt_pkg

//--- uart_line_if.sv
// Serial line between the transmitter and the remote receiver.
`timescale 1ns/1ps
`default_nettype none
interface uart_line_if;
	logic tx_level;
	logic tx_oe;
	// A released line is pulled to the idle high level.
	wire logic line = tx_oe ? tx_level : 1'b1;
	modport device (output tx_level, output tx_oe);
	modport remote (input line);
endinterface : uart_line_if
`default_nettype wire

//--- baud_tick_gen.sv
// Baud clock generator: modulus divider giving rising and falling tick enables.
`timescale 1ns/1ps
`default_nettype none
`include "uart_bt_regs.svh"
module baud_tick_gen #(
	parameter int DIV_WIDTH = `DIV_W
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic [DIV_WIDTH-1:0] divisor_in,
	output logic rise_tick_out,
	output logic fall_tick_out
);
	generate
		if (DIV_WIDTH < 2)
		begin : g_bad_width
			$error("divisor width too small");
		end
	endgenerate

	logic [DIV_WIDTH-1:0] cnt_q;
	// A divisor of zero stops the baud clock altogether.
	wire logic running = divisor_in != '0;
	wire logic wrap = running && (cnt_q >= divisor_in - 1'b1);
	wire logic [DIV_WIDTH-1:0] half = divisor_in >> 1;

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			cnt_q <= '0;
		else
			cnt_q <= wrap ? '0 : cnt_q + 1'b1;
	end

	assign rise_tick_out = wrap;
	// With a divisor of one both edges fall in one cycle, so only the rising tick is given.
	assign fall_tick_out = running && (half != '0) && (cnt_q == half - 1'b1);
endmodule : baud_tick_gen
`default_nettype wire

//--- uart_bt_device.sv
// UART baud generator, transmitter and receiver sampling controls with an APB register port.
//
// Function
// - Sampling register bits 7..2 read zero.
// - Dual edge adds falling baud samples.
// - Software enables dual edge for ratios 4-7.
// - Resync inhibit blocks mid-word bit resynchronisation.
// - Change sampling settings only while receiver disabled.
// - Thirteen-bit counter divides clock by divisor.
// - Receiver uses baud clock; transmitter divides further.
// - Receiver takes 4 to 32 samples/bit, 8 to 64 with dual edge.
// - Reset idles high; invert bit flips output.
// - Enable rising queues one idle frame.
// - Frame is 10 to 13 bits.
// - Free shifter loads buffer, sets buffer-empty flag.
// - Stop done, nothing waiting: set complete.
// - Disabling finishes current and queued characters (here a buffered data character waits until re-enable).
// - Break bit one then zero queues break.
// - Break bit still set requeues another break.
// - Break length 10 to 16 bit times.
// - Enable clear then set queues idle.
// - Brief enable clear keeps line driven (here only while a frame is shifting or an idle or break is queued).
// - Invalid ratio code means ratio sixteen.
// - Ten-bit mode adds tenth data bit.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_bt_regs.svh"
module uart_bt_device #(
	parameter int DIV_WIDTH = `DIV_W
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	uart_line_if.device line,
	output logic rx_sample_strobe_out,
	output logic rx_resync_enable_out,
	output logic [6:0] rx_samples_per_bit_out
);
	generate
		if (DIV_WIDTH != `DIV_W)
		begin : g_bad_width
			$error("baud divisor must be 13 bits wide");
		end
	endgenerate

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [5:0] ratio_of(input logic [4:0] code);
		ratio_of = (code >= `OSR_MIN) ? {1'b0, code} + 6'h01 : `OSR_DEFAULT_RATIO;
	endfunction : ratio_of

	function automatic logic [4:0] frame_len(input logic nine, input logic ten, input logic two);
		frame_len = `FRAME_BASE + (ten ? 5'h02 : {4'h0, nine}) + {4'h0, two};
	endfunction : frame_len

	// ****************************************************************
	// Register port
	// ****************************************************************
	logic [DIV_WIDTH-1:0] baud_q;
	logic [`CTRL_W-1:0] ctrl_q;
	logic [`RXS_W-1:0] rxs_q;
	logic [`DATA_W-1:0] buf_q;
	logic buf_full_q;
	logic tc_q;
	logic pready_q;

	wire logic [5:0] idx = paddr_in[`IDX_MSB:`IDX_LSB];
	wire logic sel_baud = idx == `BAUD_IDX;
	wire logic sel_ctrl = idx == `CTRL_IDX;
	wire logic sel_data = idx == `DATA_IDX;
	wire logic sel_stat = idx == `STATUS_IDX;
	wire logic sel_rxs = idx == `RX_SAMPLING_IDX;
	wire logic mapped = sel_baud | sel_ctrl | sel_data | sel_stat | sel_rxs;
	wire logic access = psel_in & penable_in;
	wire logic done = access & pready_q;
	wire logic wr = done & pwrite_in & mapped;
	wire logic wr_data = wr & sel_data;

	wire logic te = ctrl_q[`CTRL_TE];
	wire logic brk_bit = ctrl_q[`CTRL_BRK];
	wire logic nine = ctrl_q[`CTRL_NINE];
	wire logic ten = ctrl_q[`CTRL_TEN];
	wire logic two = ctrl_q[`CTRL_TWO_STOP];
	wire logic [5:0] ratio = ratio_of(ctrl_q[`CTRL_OSR_MSB:`CTRL_OSR_LSB]);
	wire logic dual = rxs_q[`RXS_DUAL_EDGE];

	wire logic [31:0] rd_word = sel_baud ? {{(32-DIV_WIDTH){1'b0}}, baud_q} :
		sel_ctrl ? {19'h0, ctrl_q} :
		sel_data ? {22'h0, buf_q} :
		sel_stat ? {30'h0, tc_q, ~buf_full_q} :
		sel_rxs ? {30'h0, rxs_q} : 32'h0;

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pready_q <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0;
		end
		else
		begin
			pready_q <= access & ~pready_q;
			pslverr_out <= access & ~pready_q & ~mapped;
			prdata_out <= (access & ~pready_q & ~pwrite_in) ? rd_word : 32'h0;
		end
	end
	assign pready_out = pready_q;

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			baud_q <= `BAUD_RESET;
			ctrl_q <= `CTRL_RESET;
			rxs_q <= `RXS_RESET;
			buf_q <= '0;
		end
		else
		begin
			if (wr & sel_baud)
				baud_q <= pwdata_in[DIV_WIDTH-1:0];
			if (wr & sel_ctrl)
				ctrl_q <= pwdata_in[`CTRL_W-1:0];
			if (wr & sel_rxs)
				rxs_q <= pwdata_in[`RXS_W-1:0];
			if (wr_data)
				buf_q <= pwdata_in[`DATA_W-1:0];
		end
	end

	// ****************************************************************
	// Baud clock and receiver sampling controls
	// ****************************************************************
	logic rise_tick;
	logic fall_tick;
	baud_tick_gen #(.DIV_WIDTH(DIV_WIDTH)) u_baud (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.divisor_in(baud_q),
		.rise_tick_out(rise_tick),
		.fall_tick_out(fall_tick)
	);

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rx_sample_strobe_out <= 1'b0;
			rx_resync_enable_out <= 1'b1;
			rx_samples_per_bit_out <= {1'b0, `OSR_DEFAULT_RATIO};
		end
		else
		begin
			rx_sample_strobe_out <= rise_tick | (dual & fall_tick);
			rx_resync_enable_out <= ~rxs_q[`RXS_RESYNC_INH];
			// A ratio of 32 doubled needs the seventh bit.
			rx_samples_per_bit_out <= dual ? {ratio, 1'b0} : {1'b0, ratio};
		end
	end

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	logic [5:0] bit_cnt_q;
	logic te_prev_q;
	logic brk_prev_q;
	logic idle_pend_q;
	logic brk_pend_q;
	logic [`SH_W-1:0] sh_q;
	logic [4:0] left_q;
	logic [`SH_W-1:0] sh_d;
	logic [4:0] left_d;

	// Comparing with >= keeps the counter bounded if the ratio is lowered mid-count.
	wire logic bit_tick = rise_tick & (bit_cnt_q >= ratio - 6'h01);
	wire logic free = bit_tick & (left_q <= 5'h01);
	wire logic load_idle = free & idle_pend_q;
	wire logic load_brk = free & ~idle_pend_q & brk_pend_q;
	wire logic load_data = free & ~idle_pend_q & ~brk_pend_q & buf_full_q & te;
	wire logic any_load = load_idle | load_brk | load_data;
	wire logic [4:0] flen = frame_len(nine, ten, two);
	wire logic [4:0] blen = flen + (ctrl_q[`CTRL_LONG_BRK] ? `LONG_BRK_EXTRA : 5'h00);
	wire logic [`DATA_W-1:0] data_ext = ten ? buf_q : nine ? {1'b1, buf_q[8:0]} : {2'h3, buf_q[7:0]};
	wire logic [`SH_W-1:0] data_frame = {5'h1f, data_ext, 1'b0};
	wire logic stop_done = bit_tick & (left_q == 5'h01) & ~any_load;

	always_comb
	begin
		sh_d = sh_q;
		left_d = left_q;
		if (load_idle)
		begin
			sh_d = {`SH_W{1'b1}};
			left_d = flen;
		end
		else if (load_brk)
		begin
			sh_d = '0;
			left_d = blen;
		end
		else if (load_data)
		begin
			sh_d = data_frame;
			left_d = flen;
		end
		else if (bit_tick && left_q > 5'h01)
		begin
			sh_d = {1'b1, sh_q[`SH_W-1:1]};
			left_d = left_q - 5'h01;
		end
		else if (bit_tick)
			left_d = 5'h00;
	end

	wire logic busy_d = left_d != 5'h00;
	wire logic level_d = busy_d ? sh_d[0] : 1'b1;

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			bit_cnt_q <= '0;
			te_prev_q <= 1'b0;
			brk_prev_q <= 1'b0;
			idle_pend_q <= 1'b0;
			brk_pend_q <= 1'b0;
			buf_full_q <= 1'b0;
			tc_q <= 1'b1;
			sh_q <= {`SH_W{1'b1}};
			left_q <= '0;
			line.tx_level <= 1'b1;
			line.tx_oe <= 1'b0;
		end
		else
		begin
			if (rise_tick)
				bit_cnt_q <= bit_tick ? '0 : bit_cnt_q + 6'h01;
			te_prev_q <= te;
			brk_prev_q <= brk_bit;
			idle_pend_q <= (te & ~te_prev_q) | (idle_pend_q & ~load_idle);
			brk_pend_q <= (~brk_bit & brk_prev_q) | (load_brk & brk_bit) | (brk_pend_q & ~load_brk);
			// A write in the loading cycle refills the buffer, so the set wins over the clear.
			buf_full_q <= wr_data | (buf_full_q & ~load_data);
			tc_q <= stop_done | (tc_q & ~wr_data);
			sh_q <= sh_d;
			left_q <= left_d;
			line.tx_level <= level_d ^ ctrl_q[`CTRL_INV];
			// The pin stays driven while enabled, while shifting, or while an idle or break is queued.
			line.tx_oe <= te | busy_d | idle_pend_q | brk_pend_q;
		end
	end
endmodule : uart_bt_device
`default_nettype wire

//--- uart_remote_rx.sv
// Remote asynchronous serial receiver at the far end of the transmit line.
`timescale 1ns/1ps
`default_nettype none
`include "uart_bt_regs.svh"
module uart_remote_rx #(
	parameter int BIT_CYCLES = 160
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	uart_line_if.remote line,
	input wire logic nine_bit_in,
	input wire logic ten_bit_in,
	output logic [9:0] rx_data_out,
	output logic rx_valid_out,
	output logic rx_framing_error_out
);
	localparam int CW = $clog2(BIT_CYCLES + 1);
	generate
		if (BIT_CYCLES < 4)
		begin : g_bad_bit
			$error("bit time too short");
		end
	endgenerate

	uart_bt_pkg::rx_state_t state_q;
	logic [CW-1:0] cnt_q;
	logic [3:0] idx_q;
	logic [9:0] sh_q;
	logic line_q;

	wire logic [3:0] last_idx = ten_bit_in ? 4'h9 : nine_bit_in ? 4'h8 : 4'h7;
	wire logic expired = cnt_q == '0;
	wire logic fall = line_q & ~line.line;
	// Data arrive lsb first; the finished word is shifted down to bit zero.
	wire logic [9:0] aligned = ten_bit_in ? sh_q : nine_bit_in ? {1'b0, sh_q[9:1]} : {2'h0, sh_q[9:2]};

	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_q <= uart_bt_pkg::RX_IDLE;
			cnt_q <= '0;
			idx_q <= '0;
			sh_q <= '0;
			line_q <= 1'b1;
			rx_data_out <= '0;
			rx_valid_out <= 1'b0;
			rx_framing_error_out <= 1'b0;
		end
		else
		begin
			line_q <= line.line;
			rx_valid_out <= 1'b0;
			if (!expired)
				cnt_q <= cnt_q - 1'b1;
			unique case (state_q)
				uart_bt_pkg::RX_IDLE:
					if (fall)
					begin
						state_q <= uart_bt_pkg::RX_START;
						cnt_q <= CW'(BIT_CYCLES / 2);
					end
				uart_bt_pkg::RX_START:
					if (expired)
					begin
						state_q <= line.line ? uart_bt_pkg::RX_IDLE : uart_bt_pkg::RX_DATA;
						cnt_q <= CW'(BIT_CYCLES - 1);
						idx_q <= '0;
					end
				uart_bt_pkg::RX_DATA:
					if (expired)
					begin
						sh_q <= {line.line, sh_q[9:1]};
						idx_q <= idx_q + 4'h1;
						cnt_q <= CW'(BIT_CYCLES - 1);
						if (idx_q == last_idx)
							state_q <= uart_bt_pkg::RX_STOP;
					end
				uart_bt_pkg::RX_STOP:
					if (expired)
					begin
						rx_data_out <= aligned;
						rx_valid_out <= 1'b1;
						rx_framing_error_out <= ~line.line;
						state_q <= uart_bt_pkg::RX_IDLE;
					end
			endcase
		end
	end
endmodule : uart_remote_rx
`default_nettype wire

//--- uart_bt_asserts.sv
// Assertion checker for the register port, sampling outputs and serial line.
`timescale 1ns/1ps
`default_nettype none
`include "uart_bt_regs.svh"
module uart_bt_asserts (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic tx_level,
	input wire logic tx_oe,
	input wire logic rx_resync_enable_out,
	input wire logic [6:0] rx_samples_per_bit_out
);
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	logic [1:0] age_q;
	wire logic rxs_hit = pready_out && psel_in && paddr_in[7:2] == `RX_SAMPLING_IDX;
	wire logic ctl_hit = pready_out && psel_in && paddr_in[7:2] == `CTRL_IDX;
	wire logic cfg_wr = pwrite_in && (rxs_hit || ctl_hit);
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			age_q <= 2'h0;
		else if (age_q != 2'h3)
			age_q <= age_q + 2'h1;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_IDLE_AFTER_RESET: assert property (age_q < 2'h2 |-> tx_level && !tx_oe)
		else $error("line not idle after reset");
	AST_RESERVED_ZERO: assert property (rxs_hit && !pwrite_in |-> prdata_out[31:2] == 30'h0)
		else $error("reserved sampling bits read nonzero");
	AST_RESYNC_BY_WRITE: assert property (!$stable(rx_resync_enable_out) |-> $past(cfg_wr) || $past(cfg_wr, 2))
		else $error("resync enable changed without a write");
	AST_SPB_BY_WRITE: assert property (!$stable(rx_samples_per_bit_out) |-> $past(cfg_wr) || $past(cfg_wr, 2))
		else $error("samples per bit changed without a write");
	AST_SPB_RANGE: assert property (rx_samples_per_bit_out >= 7'h04)
		else $error("samples per bit below four");
	AST_ANSWER_NEXT: assert property (psel_in && $rose(penable_in) |=> pready_out)
		else $error("ready not one cycle after access start");
	AST_READY_PULSE: assert property (pready_out |=> !pready_out)
		else $error("ready held two cycles");
	AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out && psel_in && penable_in)
		else $error("slave error outside a transfer end");
	cover property (rxs_hit && pwrite_in);
	cover property (pslverr_out);
	cover property ($fell(tx_level) && tx_oe);
endmodule : uart_bt_asserts
`default_nettype wire

//--- uart_baud_and_transmitter_test.sv
// Self-checking testbench joining the transmitter to the remote receiver.
`timescale 1ns/1ps
`default_nettype none
`include "uart_bt_regs.svh"
module uart_baud_and_transmitter_test;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic resync_en;
	logic [6:0] spb;
	logic strobe;
	logic nine_bit = 1'b0;
	logic ten_bit = 1'b0;
	logic [9:0] rx_data;
	logic rx_valid;
	logic rx_fe;
	logic [31:0] rd;
	logic err;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	uart_line_if line_if ();
	uart_bt_device u_uart_bt_device (.clock_in(clock_in), .reset_n_in(reset_n_in), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .line(line_if), .rx_sample_strobe_out(strobe),
		.rx_resync_enable_out(resync_en), .rx_samples_per_bit_out(spb));
	uart_remote_rx #(.BIT_CYCLES(8)) u_uart_remote_rx (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.line(line_if), .nine_bit_in(nine_bit), .ten_bit_in(ten_bit), .rx_data_out(rx_data),
		.rx_valid_out(rx_valid), .rx_framing_error_out(rx_fe));
	uart_bt_asserts u_uart_bt_asserts (.clock_in(clock_in), .reset_n_in(reset_n_in), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .tx_level(line_if.tx_level), .tx_oe(line_if.tx_oe),
		.rx_resync_enable_out(resync_en), .rx_samples_per_bit_out(spb));
	always #2.5 clock_in = ~clock_in;
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		@(posedge clock_in iff pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(what, exp, rd);
	endtask : rdchk
	task automatic count_strobes(input string what, input int exp);
		int n;
		n = 0;
		repeat (40)
		begin
			@(posedge clock_in);
			if (strobe === 1'b1)
				n++;
		end
		chk(what, exp, n);
	endtask : count_strobes
	task automatic expect_char(input logic [9:0] d, input logic fe);
		@(posedge clock_in iff rx_valid === 1'b1);
		chk("received word", {22'h0, d}, {22'h0, rx_data});
		chk("framing error", {31'h0, fe}, {31'h0, rx_fe});
	endtask : expect_char
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic reset_values();
		rdchk("baud", `BAUD_IDX, 32'h4);
		rdchk("ctrl", `CTRL_IDX, 32'hf00);
		rdchk("sampling", `RX_SAMPLING_IDX, 32'h0);
		rdchk("status", `STATUS_IDX, 32'h3);
		chk("idle level", 32'h1, {31'h0, line_if.line});
		count_strobes("rising strobes", 10);
		apb(1'b0, 6'h10, 32'h0);
		chk("slave error", 32'h1, {31'h0, err});
		chk("unmapped read", 32'h0, rd);
	endtask : reset_values
	task automatic sampling_controls();
		logic [4:0] codes [5] = '{5'h00, 5'h1f, 5'h02, 5'h07, 5'h03};
		logic [6:0] ratios [5] = '{7'h20, 7'h40, 7'h20, 7'h10, 7'h08};
		// Dual edge goes on first, so no ratio below eight is ever left single edged.
		apb(1'b1, `RX_SAMPLING_IDX, 32'h2);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, `CTRL_IDX, {19'h0, codes[i], 8'h00});
			repeat (2) @(posedge clock_in);
			chk("samples per bit", {25'h0, ratios[i]}, {25'h0, spb});
		end
		count_strobes("dual edge strobes", 20);
		apb(1'b1, `RX_SAMPLING_IDX, 32'hff);
		rdchk("sampling", `RX_SAMPLING_IDX, 32'h3);
		chk("dual edge samples", 32'h8, {25'h0, spb});
		chk("resync off", 32'h0, {31'h0, resync_en});
		apb(1'b1, `RX_SAMPLING_IDX, 32'h2);
		repeat (2) @(posedge clock_in);
		chk("resync on", 32'h1, {31'h0, resync_en});
	endtask : sampling_controls
	task automatic tx_frames();
		int n;
		apb(1'b1, `BAUD_IDX, 32'h2);
		apb(1'b1, `CTRL_IDX, 32'h301);
		apb(1'b1, `DATA_IDX, 32'h55);
		rdchk("status while full", `STATUS_IDX, 32'h0);
		n = 0;
		while (line_if.line === 1'b1)
		begin
			@(posedge clock_in);
			n++;
		end
		chk("preamble held", 32'h1, {31'h0, n >= 60});
		apb(1'b1, `DATA_IDX, 32'ha3);
		expect_char(10'h055, 1'b0);
		expect_char(10'h0a3, 1'b0);
		repeat (16) @(posedge clock_in);
		rdchk("status when done", `STATUS_IDX, 32'h3);
		chk("line idle high", 32'h1, {31'h0, line_if.line});
	endtask : tx_frames
	task automatic ten_bit_and_disable();
		ten_bit = 1'b1;
		apb(1'b1, `CTRL_IDX, 32'h311);
		apb(1'b1, `DATA_IDX, 32'h2a5);
		do
			apb(1'b0, `STATUS_IDX, 32'h0);
		while (rd[0] !== 1'b1);
		apb(1'b1, `CTRL_IDX, 32'h310);
		repeat (2) @(posedge clock_in);
		chk("driven while disabling", 32'h1, {31'h0, line_if.tx_oe});
		expect_char(10'h2a5, 1'b0);
		repeat (8) @(posedge clock_in);
		chk("released when done", 32'h0, {31'h0, line_if.tx_oe});
		ten_bit = 1'b0;
	endtask : ten_bit_and_disable
	task automatic breaks();
		logic [31:0] ctrl [3] = '{32'h301, 32'h341, 32'h329};
		int lens [3] = '{80, 104, 96};
		int n;
		int m;
		for (int i = 0; i < 3; i++)
		begin
			// The first pass re-enables the transmitter, so an idle frame comes before the break.
			apb(1'b1, `CTRL_IDX, ctrl[i]);
			apb(1'b1, `CTRL_IDX, ctrl[i] | 32'h2);
			apb(1'b1, `CTRL_IDX, ctrl[i]);
			n = 0;
			m = 0;
			fork
				begin
					while (line_if.line !== 1'b0)
					begin
						@(posedge clock_in);
						m++;
					end
					while (line_if.line === 1'b0)
					begin
						@(posedge clock_in);
						n++;
					end
				end
				expect_char(10'h000, 1'b1);
			join
			chk("break length", lens[i], n);
			chk("idle before break", 32'h1, {31'h0, (i == 0) == (m >= 60)});
		end
	endtask : breaks
	// Inversion runs last: the inverted idle level looks like a start bit to the remote receiver.
	task automatic inversion();
		apb(1'b1, `CTRL_IDX, 32'h305);
		repeat (2) @(posedge clock_in);
		chk("inverted idle", 32'h0, {31'h0, line_if.line});
	endtask : inversion
	always @(posedge clock_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (5) @(posedge clock_in);
		reset_n_in <= 1'b1;
		reset_values();
		sampling_controls();
		tx_frames();
		ten_bit_and_disable();
		breaks();
		inversion();
		tally_and_finish();
	end
endmodule : uart_baud_and_transmitter_test
`default_nettype wire
